/* File: tpg_gpio.sv */
// Overview of operation
// - Sixteen bidirectional pins: seven on port 0, seven on port 1, two on port 2.
// - Reset leaves every pin in plain I/O mode, all function fields zero.
// - In power-saving mode every pin holds its driven level and configuration.
// - Function code 00 gives plain I/O, code 01 the peripheral alternate function.
// - Pin n function code sits at bits 4n+1:4n; other bits reserved.
// - Data register bits 31:24 set direction, 1 output, 0 input.
// - Data register bits 23:16 hold the value driven on output pins.
// - Data register bits 15:8 read back pin levels captured at reset.
// - Data register bits 7:0 read back the current sampled pin levels.
// - Writing 1 to set register bits 23:16 sets that output bit.
// - Writing 1 to clear register bits 23:16 clears that output bit.
// - A set lock bit makes writes to that pin's function and data bits ignored.
// - Drive strength bit 0 selects 2 mA source current, 1 selects 4 mA.
// - Pull-up disable bit 0 keeps pull-up on, 1 switches it off.
// - Port 0 pin 2 pull-up stays on whatever its disable bit holds.
`timescale 1ns/1ps
`default_nettype none
module tpg_gpio (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [31:0]                 paddr,
   input  wire logic [31:0]                 pwdata,
   input  wire logic [3:0]                  pstrb,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        sleep_mode,
   input  wire logic [2:0][7:0]             pad_in,
   output wire tpg_pkg::tpg_pad_type [2:0]  pad,
   input  wire logic [2:0][7:0]             alt_out,
   input  wire logic [2:0][7:0]             alt_out_en,
   output wire logic [2:0][7:0]             alt_in
);

   logic              setup_phase;
   logic              wr_take;
   logic              rd_take;
   logic              pad_load;
   logic [31:0]       lane_bits;
   logic [31:0]       rd_word;
   logic              addr_hit;
   logic              rst_cap_done_q;
   wire  [2:0][31:0]  port_rd;
   wire  [2:0]        port_hit;

   // Setup cycle of a transfer
   assign setup_phase = psel & ~penable;

   // Write taken at the access edge, when ready is high
   assign wr_take     = psel & penable & pwrite & pready;

   // Read request seen in the setup cycle
   assign rd_take     = setup_phase & ~pwrite;

   // Pads take new values only outside power-saving mode
   assign pad_load    = ~sleep_mode;

   // Byte lanes that a write may touch
   assign lane_bits = {{tpg_pkg::LANE_W{pstrb[3]}}, {tpg_pkg::LANE_W{pstrb[2]}},
                       {tpg_pkg::LANE_W{pstrb[1]}}, {tpg_pkg::LANE_W{pstrb[0]}}};

   // Any port claiming the address
   assign addr_hit = |port_hit;

   // Read word: only the addressed port returns a nonzero word
   always_comb begin
      rd_word = tpg_pkg::WORD_ZERO;
      for (int p = 0; p < tpg_pkg::NUM_PORTS; p++) begin
         rd_word = rd_word | port_rd[p];
      end
   end

   // Ready answers in the first access cycle, no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup_phase;
      end
   end

   // Error answer for an address outside the map
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= setup_phase & ~addr_hit;
      end
   end

   // Read data latched in the setup cycle, zero for writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= tpg_pkg::WORD_ZERO;
      end else if (rd_take) begin
         prdata <= rd_word;
      end else if (setup_phase) begin
         prdata <= tpg_pkg::WORD_ZERO;
      end
   end

   // Marks that the reset-time pin levels have been caught
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_cap_done_q <= 1'b0;
      end else begin
         rst_cap_done_q <= 1'b1;
      end
   end

   // One block per port; pins beyond the port's count stay at zero
   for (genvar p = 0; p < tpg_pkg::NUM_PORTS; p++) begin : g_port
      localparam logic [7:0] MASK = tpg_pkg::PIN_MASK[p];

      logic [7:0][1:0] fsel_q;
      logic [7:0]      dir_q;
      logic [7:0]      out_q;
      logic [7:0]      lock_q;
      logic [7:0]      ds_q;
      logic [7:0]      pd_q;
      logic [7:0]      in_q;
      logic [7:0]      rstv_q;
      logic [7:0]      drv_q;
      logic [7:0]      oe_q;
      logic [7:0]      pu_q;
      logic [7:0]      dss_q;
      logic [7:0]      out_d;
      logic [7:0]      drv_d;
      logic [7:0]      oe_d;
      logic [7:0]      alt_sel;
      logic [7:0]      pu_d;
      logic [7:0]      pin_open;
      logic [31:0]     fsel_rd;
      logic [31:0]     port_word;
      logic            hit_fsel;
      logic            hit_data;
      logic            hit_set;
      logic            hit_clr;
      logic            hit_par;
      logic            wr_fsel;
      logic            wr_data;
      logic            wr_set;
      logic            wr_clr;
      logic            wr_par;

      // Address decode for this port
      assign hit_fsel = (paddr == tpg_pkg::ADDR_FSEL[p]);
      assign hit_data = (paddr == tpg_pkg::ADDR_DATA[p]);
      assign hit_set  = (paddr == tpg_pkg::ADDR_SET[p]);
      assign hit_clr  = (paddr == tpg_pkg::ADDR_CLR[p]);
      assign hit_par  = (paddr == tpg_pkg::ADDR_PAR[p]);
      assign port_hit[p] = hit_fsel | hit_data | hit_set | hit_clr | hit_par;

      // Write strobes of this port, taken at the access edge only
      assign wr_fsel = wr_take & hit_fsel;
      assign wr_data = wr_take & hit_data;
      assign wr_set  = wr_take & hit_set;
      assign wr_clr  = wr_take & hit_clr;
      assign wr_par  = wr_take & hit_par;

      // Pins open to function and data writes: implemented and unlocked
      assign pin_open = MASK & ~lock_q;

      // Function select fields; locked pins ignore writes
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            for (int n = 0; n < tpg_pkg::PORT_W; n++) begin
               fsel_q[n] <= tpg_pkg::FSEL_RST;
            end
         end else if (wr_fsel) begin
            for (int n = 0; n < tpg_pkg::PORT_W; n++) begin
               for (int b = 0; b < tpg_pkg::FSEL_W; b++) begin
                  if (pin_open[n] && lane_bits[tpg_pkg::FSEL_STRIDE*n+b]) begin
                     fsel_q[n][b] <= pwdata[tpg_pkg::FSEL_STRIDE*n+b];
                  end
               end
            end
         end
      end

      // Direction bits from data register writes
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            dir_q <= tpg_pkg::BYTE_RST;
         end else if (wr_data) begin
            for (int n = 0; n < tpg_pkg::PORT_W; n++) begin
               if (pin_open[n] && lane_bits[tpg_pkg::DIR_LSB+n]) begin
                  dir_q[n] <= pwdata[tpg_pkg::DIR_LSB+n];
               end
            end
         end
      end

      // Next output byte from data, set and clear writes
      always_comb begin
         out_d = out_q;
         for (int n = 0; n < tpg_pkg::PORT_W; n++) begin
            if (pin_open[n] && lane_bits[tpg_pkg::OUT_LSB+n]) begin
               if (wr_data) begin
                  out_d[n] = pwdata[tpg_pkg::OUT_LSB+n];
               end else if (wr_set && pwdata[tpg_pkg::OUT_LSB+n]) begin
                  out_d[n] = 1'b1;
               end else if (wr_clr && pwdata[tpg_pkg::OUT_LSB+n]) begin
                  out_d[n] = 1'b0;
               end
            end
         end
      end

      // Output data byte, shared by data, set and clear registers
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            out_q <= tpg_pkg::BYTE_RST;
         end else begin
            out_q <= out_d;
         end
      end

      // Lock bits of the parameter register; never blocked by themselves
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            lock_q <= tpg_pkg::BYTE_RST;
         end else if (wr_par) begin
            for (int n = 0; n < tpg_pkg::PORT_W; n++) begin
               if (MASK[n] && lane_bits[tpg_pkg::LOCK_LSB+n]) begin
                  lock_q[n] <= pwdata[tpg_pkg::LOCK_LSB+n];
               end
            end
         end
      end

      // Drive strength bits of the parameter register
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ds_q <= tpg_pkg::BYTE_RST;
         end else if (wr_par) begin
            for (int n = 0; n < tpg_pkg::PORT_W; n++) begin
               if (MASK[n] && lane_bits[tpg_pkg::DS_LSB+n]) begin
                  ds_q[n] <= pwdata[tpg_pkg::DS_LSB+n];
               end
            end
         end
      end

      // Pull-up disable bits of the parameter register
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pd_q <= tpg_pkg::BYTE_RST;
         end else if (wr_par) begin
            for (int n = 0; n < tpg_pkg::PORT_W; n++) begin
               if (MASK[n] && lane_bits[tpg_pkg::PD_LSB+n]) begin
                  pd_q[n] <= pwdata[tpg_pkg::PD_LSB+n];
               end
            end
         end
      end

      // Pin levels sampled every cycle
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            in_q <= tpg_pkg::BYTE_RST;
         end else begin
            in_q <= pad_in[p] & MASK;
         end
      end

      // Pin levels caught at the first edge after reset release
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            rstv_q <= tpg_pkg::BYTE_RST;
         end else if (!rst_cap_done_q) begin
            rstv_q <= pad_in[p] & MASK;
         end
      end

      // Pad controls: alternate function or plain I/O per pin
      always_comb begin
         for (int n = 0; n < tpg_pkg::PORT_W; n++) begin
            alt_sel[n] = (fsel_q[n] == tpg_pkg::FUNC_ALT);
         end
      end

      // Pull-up on unless disabled; forced pins always on
      assign pu_d = MASK & (~pd_q | tpg_pkg::PULLUP_FORCED[p]);

      // Next pad drive and enable: peripheral when selected, else port registers
      always_comb begin
         drv_d = tpg_pkg::BYTE_RST;
         oe_d  = tpg_pkg::BYTE_RST;
         for (int n = 0; n < tpg_pkg::PORT_W; n++) begin
            if (MASK[n] && alt_sel[n]) begin
               drv_d[n] = alt_out[p][n];
               oe_d[n]  = alt_out_en[p][n];
            end else if (MASK[n]) begin
               drv_d[n] = out_q[n];
               oe_d[n]  = dir_q[n];
            end
         end
      end

      // Pad drive level; frozen while in power-saving mode
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            drv_q <= tpg_pkg::BYTE_RST;
         end else if (pad_load) begin
            drv_q <= drv_d;
         end
      end

      // Pad output enable; frozen while in power-saving mode
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            oe_q <= tpg_pkg::BYTE_RST;
         end else if (pad_load) begin
            oe_q <= oe_d;
         end
      end

      // Pad pull-up enable; frozen while in power-saving mode
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pu_q <= tpg_pkg::BYTE_RST;
         end else if (pad_load) begin
            pu_q <= pu_d;
         end
      end

      // Pad drive strength; frozen while in power-saving mode
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            dss_q <= tpg_pkg::BYTE_RST;
         end else if (pad_load) begin
            dss_q <= MASK & ds_q;
         end
      end

      // Function-select read word, reserved bits zero
      always_comb begin
         fsel_rd = tpg_pkg::WORD_ZERO;
         for (int n = 0; n < tpg_pkg::PORT_W; n++) begin
            for (int b = 0; b < tpg_pkg::FSEL_W; b++) begin
               fsel_rd[tpg_pkg::FSEL_STRIDE*n+b] = fsel_q[n][b];
            end
         end
      end

      // Read word of this port; set and clear read as zero
      always_comb begin
         port_word = tpg_pkg::WORD_ZERO;
         if (hit_fsel) begin
            port_word = fsel_rd;
         end else if (hit_data) begin
            port_word = {dir_q, out_q, rstv_q, in_q};
         end else if (hit_par) begin
            port_word = {tpg_pkg::BYTE_RST, lock_q, ds_q, pd_q};
         end
      end
      assign port_rd[p] = port_word;

      // Pads and peripheral inputs
      assign pad[p].drive        = drv_q;
      assign pad[p].out_en       = oe_q;
      assign pad[p].pullup_en    = pu_q;
      assign pad[p].drive_strong = dss_q;
      assign alt_in[p]           = in_q;
   end

endmodule
`default_nettype wire

/* File: tpg_pkg.sv */
`default_nettype none
package tpg_pkg;

   // Port and pin counts
   localparam int NUM_PORTS = 3;
   localparam int PORT_W    = 8;
   localparam int LANE_W    = 8;

   // Implemented pins per port (7, 7 and 2 pins: sixteen in all)
   localparam logic [2:0][7:0] PIN_MASK = {8'h03, 8'h7F, 8'h7F};

   // Pins whose pull-up can never be switched off (port0_pin2)
   localparam logic [2:0][7:0] PULLUP_FORCED = {8'h00, 8'h00, 8'h04};

   // Byte addresses of the register map, index 0 is port 0
   localparam logic [2:0][31:0] ADDR_FSEL = {32'hFFFF0D08, 32'hFFFF0D04, 32'hFFFF0D00};
   localparam logic [2:0][31:0] ADDR_DATA = {32'hFFFF0D40, 32'hFFFF0D30, 32'hFFFF0D20};
   localparam logic [2:0][31:0] ADDR_SET  = {32'hFFFF0D44, 32'hFFFF0D34, 32'hFFFF0D24};
   localparam logic [2:0][31:0] ADDR_CLR  = {32'hFFFF0D48, 32'hFFFF0D38, 32'hFFFF0D28};
   localparam logic [2:0][31:0] ADDR_PAR  = {32'hFFFF0D4C, 32'hFFFF0D3C, 32'hFFFF0D2C};

   // Function-select field layout: pin n at bits FSEL_STRIDE*n+1 : FSEL_STRIDE*n
   localparam int FSEL_STRIDE = 4;
   localparam int FSEL_W      = 2;

   // Port data register fields
   localparam int DIR_LSB  = 24;
   localparam int OUT_LSB  = 16;
   localparam int RSTV_LSB = 8;
   localparam int IN_LSB   = 0;

   // Port parameter register fields
   localparam int LOCK_LSB = 16;
   localparam int DS_LSB   = 8;
   localparam int PD_LSB   = 0;

   // Function codes
   localparam logic [1:0] FUNC_GPIO = 2'h0;
   localparam logic [1:0] FUNC_ALT  = 2'h1;

   // Reset values
   localparam logic [1:0]  FSEL_RST = 2'h0;
   localparam logic [7:0]  BYTE_RST = 8'h00;
   localparam logic [31:0] WORD_ZERO = 32'h00000000;

   // Drive, enable, pull-up and strength of one port's pads
   typedef struct packed {
      logic [7:0] drive;
      logic [7:0] out_en;
      logic [7:0] pullup_en;
      logic [7:0] drive_strong;
   } tpg_pad_type;

endpackage
`default_nettype wire

/* File: tpg_gpio_props.sv */
`timescale 1ns/1ps
`default_nettype none
module tpg_gpio_props (
   input wire logic                       pclk,
   input wire logic                       presetn,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [31:0]                paddr,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic                       sleep_mode,
   input wire logic [2:0][7:0]            pad_in,
   input wire tpg_pkg::tpg_pad_type [2:0] pad,
   input wire logic [2:0][7:0]            alt_in
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Pin outputs and bus answer
   a_unused_pins: assert property (({pad[2].out_en, pad[1].out_en, pad[0].out_en}
      & ~tpg_pkg::PIN_MASK) == '0) else $error("unused pin driven");
   a_reset_quiet: assert property (disable iff (1'b0) !presetn |-> pad == '0 && !pready)
      else $error("outputs active in reset");
   a_sleep_hold: assert property (sleep_mode |=> $stable(pad))
      else $error("pads moved in sleep");
   a_input_sample: assert property ($past(presetn) |->
      alt_in == ($past(pad_in) & tpg_pkg::PIN_MASK)) else $error("input sample wrong");
   a_pullup_forced: assert property ($past(presetn) |-> pad[0].pullup_en[2])
      else $error("forced pull-up off");
   a_setclr_read: assert property (psel && penable && pready && !pwrite
      && paddr[31:8] == 24'hFFFF0D && paddr[7:4] != 4'h0 && paddr[3:0] inside {4'h4, 4'h8}
      |-> prdata == '0) else $error("set or clear read not zero");
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready) else $error("ready too long");
   a_err_unmapped: assert property (psel && !penable && paddr[31:8] != 24'hFFFF0D
      |=> pslverr) else $error("no error on unmapped");
endmodule

bind tpg_gpio tpg_gpio_props i_tpg_gpio_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .sleep_mode(sleep_mode), .pad_in(pad_in), .pad(pad), .alt_in(alt_in));
`default_nettype wire

/* File: tpg_pins.sv */
`timescale 1ns/1ps
`default_nettype none
module tpg_pins (
   input  wire logic                       pclk,
   input  wire tpg_pkg::tpg_pad_type [2:0] pad,
   input  wire logic [2:0][7:0]            ext_lvl,
   input  wire logic [2:0][7:0]            ext_en,
   output logic      [2:0][7:0]            pad_in
);
   logic [2:0][7:0] flt_q = '0;

   // A pin nobody drives and without pull-up wanders every cycle
   always_ff @(posedge pclk) flt_q <= ~flt_q;

   // Pin level: own driver first, then outside driver, then pull-up
   always_comb
      for (int p = 0; p < 3; p++)
         for (int b = 0; b < 8; b++)
            pad_in[p][b] = pad[p].out_en[b] ? pad[p].drive[b] :
               ext_en[p][b] ? ext_lvl[p][b] : pad[p].pullup_en[b] | flt_q[p][b];
endmodule
`default_nettype wire

/* File: tb_three_port_gpio_with_mux.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_three_port_gpio_with_mux;
   localparam logic [2:0][7:0] EXT = 24'h01305A;
   logic                       pclk = 0, presetn, psel = 0, penable = 0, pwrite = 0;
   logic [3:0]                 pstrb = 4'hF;
   logic                       sleep_mode = 0, pready, pslverr, err_q;
   logic [31:0]                paddr = '0, pwdata = '0, prdata, rd_q;
   logic [2:0][7:0]            pad_in, alt_in, alt_out = '0, alt_out_en = '0, ext_en = '1;
   tpg_pkg::tpg_pad_type [2:0] pad;
   int                         n_errors = 0, n_compared = 0;

   always #50 pclk = ~pclk;

   tpg_gpio i_tpg_gpio (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode), .pad_in(pad_in),
      .pad(pad), .alt_out(alt_out), .alt_out_en(alt_out_en), .alt_in(alt_in));
   tpg_pins i_tpg_pins (.pclk(pclk), .pad(pad), .ext_lvl(EXT), .ext_en(ext_en),
      .pad_in(pad_in));

   // One APB transfer, held until ready is sampled high
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task chk_rd(input logic [31:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd_q, e)
   endtask

   task settle;
      repeat (2) @(posedge pclk);
   endtask

   task t_reset;
      for (int p = 0; p < 3; p++) begin
         chk_rd(tpg_pkg::ADDR_FSEL[p], 32'h0);
         chk_rd(tpg_pkg::ADDR_PAR[p], 32'h0);
         chk_rd(tpg_pkg::ADDR_DATA[p], {16'h0, {2{EXT[p] & tpg_pkg::PIN_MASK[p]}}});
      end
      $display("reset values done");
   endtask

   task t_dir;
      ext_en[1] <= 8'hF0;
      apb(1'b1, tpg_pkg::ADDR_DATA[1], 32'h0F050000);
      settle;
      `CHK({pad[1].out_en, pad[1].drive}, 16'h0F05)
      chk_rd(tpg_pkg::ADDR_DATA[1], 32'h0F053035);
      `CHK(alt_in[1], 8'h35)
      apb(1'b1, tpg_pkg::ADDR_SET[1], 32'h00F00000);
      apb(1'b1, tpg_pkg::ADDR_CLR[1], 32'h00010000);
      chk_rd(tpg_pkg::ADDR_SET[1], 32'h0);
      chk_rd(tpg_pkg::ADDR_DATA[1], 32'h0F743034);
      $display("direction and set clear done");
   endtask

   task t_lock;
      apb(1'b1, tpg_pkg::ADDR_PAR[0], 32'h00010000);
      apb(1'b1, tpg_pkg::ADDR_DATA[0], 32'hFFFF0000);
      apb(1'b1, tpg_pkg::ADDR_FSEL[0], 32'hFFFFFFFF);
      chk_rd(tpg_pkg::ADDR_FSEL[0], 32'h03333330);
      chk_rd(tpg_pkg::ADDR_DATA[0], 32'h7E7E5A7E);
      apb(1'b1, tpg_pkg::ADDR_PAR[0], 32'h00000F0F);
      apb(1'b1, tpg_pkg::ADDR_DATA[0], 32'h0);
      settle;
      `CHK({pad[0].drive_strong, pad[0].pullup_en}, 16'h0F74)
      pstrb <= 4'h1;
      apb(1'b1, tpg_pkg::ADDR_PAR[0], 32'hFFFFFFFF);
      pstrb <= 4'hF;
      chk_rd(tpg_pkg::ADDR_PAR[0], 32'h00000F7F);
      $display("lock and parameters done");
   endtask

   task t_func;
      apb(1'b1, tpg_pkg::ADDR_FSEL[2], 32'hFFFFFFFF);
      chk_rd(tpg_pkg::ADDR_FSEL[2], 32'h00000033);
      alt_out[2] <= 8'h02;
      alt_out_en[2] <= 8'h03;
      apb(1'b1, tpg_pkg::ADDR_FSEL[2], 32'h00000011);
      settle;
      `CHK({pad[2].out_en, pad[2].drive}, 16'h0302)
      apb(1'b1, tpg_pkg::ADDR_FSEL[2], 32'h0);
      apb(1'b1, tpg_pkg::ADDR_DATA[2], 32'h01010000);
      settle;
      `CHK({pad[2].out_en, pad[2].drive}, 16'h0101)
      $display("function select done");
   endtask

   task t_sleep_err;
      sleep_mode <= 1'b1;
      apb(1'b1, tpg_pkg::ADDR_DATA[1], 32'h7F000000);
      settle;
      `CHK(pad[1].out_en, 8'h0F)
      sleep_mode <= 1'b0;
      settle;
      `CHK(pad[1].out_en, 8'h7F)
      apb(1'b0, 32'hFFFF0D10, 32'h0);
      `CHK({err_q, rd_q}, 33'h100000000)
      apb(1'b0, 32'h00000D20, 32'h0);
      `CHK({err_q, rd_q}, 33'h100000000)
      $display("sleep and unmapped done");
   endtask

   task print_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      // Falling reset at time zero gives the asynchronous reset its edge
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_dir;
      t_lock;
      t_func;
      t_sleep_err;
      print_verdict;
   end

   // Watchdog well beyond the roughly 130 cycles the tests need
   initial begin
      repeat (3000) @(posedge pclk);
      n_errors++;
      print_verdict;
   end
endmodule
`default_nettype wire
